// >>> common/pac_defines.svh
`ifndef PAC_DEFINES_SVH
`define PAC_DEFINES_SVH

// Register word indexes on the management port
`define PAC_ADDR_PARTNER 5'h05
`define PAC_ADDR_IRQ_STATUS 5'h10
`define PAC_ADDR_IRQ_MASK 5'h11
`define PAC_ADDR_CONTROL 5'h12
`define PAC_ADDR_BASE_COPY 5'h13
`define PAC_ADDR_STATE 5'h14

// Partner ability page fields
`define PAC_BIT_NEXT_PAGE_REQUEST 15
`define PAC_BIT_ACK 14
`define PAC_BIT_FAR_END_FAULT 13
`define PAC_BIT_RESERVED 12
`define PAC_BIT_ONE_WAY_FLOW 11
`define PAC_BIT_PAUSE 10
`define PAC_BIT_T4 9
`define PAC_BIT_HUNDRED_FULL 8
`define PAC_BIT_HUNDRED 7
`define PAC_BIT_TEN_FULL 6
`define PAC_BIT_TEN 5
`define PAC_SEL_MSB 4
`define PAC_SEL_LSB 0

// Interrupt status and mask bits
`define PAC_EVT_BASE_RX 0
`define PAC_EVT_NEXT_RX 1
`define PAC_EVT_FAULT 2
`define PAC_EVT_CHANGE 3
`define PAC_EVT_VIEW_NEXT 4
`define PAC_EVT_WIDTH 5

// Control register bits
`define PAC_CTL_NEXT_PAGE_EN 0

// Reset values
`define PAC_PAGE_RESET 16'h0000
`define PAC_MASK_RESET 5'h00
`define PAC_CTL_NEXT_PAGE_EN_RESET 1'b1

`endif

// >>> common/pac_pkg.sv
package pac_pkg;

  typedef logic [15:0] pac_word_type;
  typedef logic [4:0] pac_addr_type;
  typedef logic [4:0] pac_event_type;

  typedef enum logic {
    VIEW_BASE,
    VIEW_NEXT
  } pac_view_type;

  typedef struct packed {
    pac_word_type basePage;
    pac_word_type nextPage;
    logic nextSeen;
    logic baseLoaded;
    logic nextLoaded;
  } pac_capture_state_type;

  typedef struct packed {
    pac_view_type view;
    pac_word_type rdData;
    pac_event_type status;
    pac_event_type mask;
    logic nextPageOn;
    logic irq;
    pac_word_type prevBase;
  } pac_main_state_type;

endpackage

// >>> common/pac_cap_if.sv
`timescale 1ns/1ps
interface pac_cap_if;
  import pac_pkg::*;
  pac_word_type basePage;
  pac_word_type nextPage;
  logic nextSeen;
  logic baseLoaded;
  logic nextLoaded;

  modport cap (
    output basePage,
    output nextPage,
    output nextSeen,
    output baseLoaded,
    output nextLoaded
  );

  modport user (
    input basePage,
    input nextPage,
    input nextSeen,
    input baseLoaded,
    input nextLoaded
  );
endinterface

// >>> verilog/pac_word_capture.sv
`timescale 1ns/1ps
`include "pac_defines.svh"
module pac_word_capture (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wordStrobe,
  input wire logic wordError,
  input wire logic wordIsNext,
  input wire pac_pkg::pac_word_type word,
  input wire logic negRestart,
  pac_cap_if.cap capBus
);
  import pac_pkg::*;

  pac_capture_state_type state;
  pac_capture_state_type next_state;
  logic wordGood;

  // Damaged or partial words never reach the register
  assign wordGood = wordStrobe && !wordError;

  always_comb begin
    next_state = state;
    next_state.baseLoaded = 1'b0;
    next_state.nextLoaded = 1'b0;
    if (negRestart) begin
      // Old next page must not shadow a fresh base page
      next_state.nextSeen = 1'b0;
    end
    if (wordGood && !wordIsNext) begin
      next_state.basePage = word;
      next_state.basePage[`PAC_BIT_RESERVED] = 1'b0;
      next_state.baseLoaded = 1'b1;
    end
    if (wordGood && wordIsNext) begin
      next_state.nextPage = word;
      next_state.nextSeen = 1'b1;
      next_state.nextLoaded = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state.basePage <= `PAC_PAGE_RESET;
      state.nextPage <= `PAC_PAGE_RESET;
      state.nextSeen <= 1'b0;
      state.baseLoaded <= 1'b0;
      state.nextLoaded <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign capBus.basePage = state.basePage;
  assign capBus.nextPage = state.nextPage;
  assign capBus.nextSeen = state.nextSeen;
  assign capBus.baseLoaded = state.baseLoaded;
  assign capBus.nextLoaded = state.nextLoaded;
endmodule

// >>> verilog/pac_partner_ability.sv
`timescale 1ns/1ps
`include "pac_defines.svh"
module pac_partner_ability (
  input wire logic clk,
  input wire logic rst_n,
  input wire pac_pkg::pac_addr_type regAddr,
  input wire pac_pkg::pac_word_type regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output pac_pkg::pac_word_type regRdData,
  input wire logic wordStrobe,
  input wire logic wordError,
  input wire logic wordIsNext,
  input wire pac_pkg::pac_word_type word,
  input wire logic negRestart,
  input wire logic negComplete,
  output logic nextPageEnable,
  output logic irq
);
  import pac_pkg::*;

  pac_cap_if capBus ();

  pac_main_state_type state;
  pac_main_state_type next_state;
  pac_word_type partnerView;
  pac_event_type events;
  pac_event_type statusKept;
  logic showNext;

  pac_word_capture capture (
    .clk(clk),
    .rst_n(rst_n),
    .wordStrobe(wordStrobe),
    .wordError(wordError),
    .wordIsNext(wordIsNext),
    .word(word),
    .negRestart(negRestart),
    .capBus(capBus)
  );

  // Next page view only after a finished exchange with next pages on
  assign showNext = state.nextPageOn && negComplete && capBus.nextSeen;

  always_comb begin
    if (state.view == VIEW_NEXT) begin
      partnerView = capBus.nextPage;
    end else begin
      partnerView = capBus.basePage;
    end
  end

  always_comb begin
    events = '0;
    events[`PAC_EVT_BASE_RX] = capBus.baseLoaded;
    events[`PAC_EVT_NEXT_RX] = capBus.nextLoaded;
    events[`PAC_EVT_FAULT] = capBus.baseLoaded
      && capBus.basePage[`PAC_BIT_FAR_END_FAULT];
    events[`PAC_EVT_CHANGE] = capBus.baseLoaded
      && (capBus.basePage != state.prevBase);
    events[`PAC_EVT_VIEW_NEXT] = showNext && (state.view == VIEW_BASE);
  end

  // Read clears status, but a same-cycle event survives
  always_comb begin
    if (regRd && regAddr == `PAC_ADDR_IRQ_STATUS) begin
      statusKept = '0;
    end else begin
      statusKept = state.status;
    end
  end

  always_comb begin
    next_state = state;
    next_state.status = statusKept | events;
    if (capBus.baseLoaded) begin
      next_state.prevBase = capBus.basePage;
    end

    unique case (state.view)
      VIEW_BASE: begin
        if (showNext) begin
          next_state.view = VIEW_NEXT;
        end
      end
      VIEW_NEXT: begin
        if (!showNext) begin
          next_state.view = VIEW_BASE;
        end
      end
    endcase

    // Only mask and control accept writes; 05h has no write path
    if (regWr) begin
      unique case (regAddr)
        `PAC_ADDR_IRQ_MASK: begin
          next_state.mask = regWrData[`PAC_EVT_WIDTH-1:0];
        end
        `PAC_ADDR_CONTROL: begin
          next_state.nextPageOn = regWrData[`PAC_CTL_NEXT_PAGE_EN];
        end
        default: begin
          next_state.mask = state.mask;
        end
      endcase
    end

    next_state.rdData = '0;
    if (regRd) begin
      unique case (regAddr)
        `PAC_ADDR_PARTNER: begin
          next_state.rdData = partnerView;
        end
        `PAC_ADDR_IRQ_STATUS: begin
          next_state.rdData = {11'h000, state.status};
        end
        `PAC_ADDR_IRQ_MASK: begin
          next_state.rdData = {11'h000, state.mask};
        end
        `PAC_ADDR_CONTROL: begin
          next_state.rdData = {15'h0000, state.nextPageOn};
        end
        `PAC_ADDR_BASE_COPY: begin
          next_state.rdData = capBus.basePage;
        end
        `PAC_ADDR_STATE: begin
          next_state.rdData = {13'h0000, negComplete, capBus.nextSeen,
            state.view == VIEW_NEXT};
        end
        default: begin
          next_state.rdData = '0;
        end
      endcase
    end

    // Level interrupt from the next value keeps it aligned with status
    next_state.irq = |(next_state.status & next_state.mask);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state.view <= VIEW_BASE;
      state.rdData <= `PAC_PAGE_RESET;
      state.status <= '0;
      state.mask <= `PAC_MASK_RESET;
      state.nextPageOn <= `PAC_CTL_NEXT_PAGE_EN_RESET;
      state.irq <= 1'b0;
      state.prevBase <= `PAC_PAGE_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign regRdData = state.rdData;
  assign nextPageEnable = state.nextPageOn;
  assign irq = state.irq;
endmodule

// >>> sim/pac_properties.sv
`timescale 1ns/1ps
module pac_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire pac_pkg::pac_addr_type regAddr,
  input wire pac_pkg::pac_word_type regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire pac_pkg::pac_word_type regRdData,
  input wire logic wordStrobe,
  input wire logic wordError,
  input wire logic wordIsNext,
  input wire pac_pkg::pac_word_type word,
  input wire logic negRestart,
  input wire logic negComplete,
  input wire logic nextPageEnable,
  input wire logic irq
);
  import pac_pkg::*;
  logic q, rd5, ctl, hold, pageBit;
  assign q = !wordStrobe && !negComplete;
  assign rd5 = regRd && regAddr == 5'h05;
  assign ctl = regWr && regAddr == 5'h12;
  assign hold = negComplete && nextPageEnable && !negRestart && !wordStrobe;
  assign pageBit = regWrData[0];
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // View must sit on the base page, so completion stays low throughout
  sequence s_base;
    wordStrobe && !wordError && !wordIsNext && !negComplete
      && !$past(negComplete) ##1 q ##1 q && rd5;
  endsequence
  sequence s_next;
    wordStrobe && !wordError && wordIsNext && negComplete
      && nextPageEnable && !negRestart ##1 hold [*4] ##1 hold && rd5;
  endsequence
  sequence s_rmw;
    q && rd5 && !$past(negComplete) ##1 q ##1 q && regWr
      && regAddr == 5'h05 ##1 q ##1 q && rd5;
  endsequence
  chk_rd_idle: assert property (!regRd |=> regRdData == 16'h0000)
    else $error("read data not idle");
  chk_base_load: assert property (s_base |=>
    regRdData == ($past(word, 3) & 16'hEFFF)) else $error("base page");
  chk_resv_read: assert property (rd5 && !negComplete
    && !$past(negComplete) |=> !regRdData[12]) else $error("bit 12 set");
  chk_err_drop: assert property (!irq && wordStrobe && wordError
    && !regWr && !negComplete && !$past(regWr) && !$past(wordStrobe)
    && !$past(negComplete) ##1 !wordStrobe && !regWr && !negComplete
    |=> !irq) else $error("bad word raised irq");
  chk_ro_write: assert property (s_rmw |=>
    regRdData == $past(regRdData, 4)) else $error("write changed page");
  chk_page_ctl: assert property (ctl |=> nextPageEnable == $past(pageBit))
    else $error("control not taken");
  chk_page_hold: assert property (!ctl |=> $stable(nextPageEnable))
    else $error("control moved");
  chk_view_next: assert property (s_next |=>
    regRdData == $past(word, 6)) else $error("next page view");
endmodule

// >>> sim/pac_link_partner.sv
`timescale 1ns/1ps
module pac_link_partner (
  input wire logic clk,
  output logic wordStrobe,
  output logic wordError,
  output logic wordIsNext,
  output pac_pkg::pac_word_type word
);
  import pac_pkg::*;
  initial begin
    wordStrobe = 1'b0;
    wordError = 1'b0;
    wordIsNext = 1'b0;
    word = 16'h0000;
  end
  // Lines flip after each word so a stale word never passes for news
  task automatic send(input pac_word_type w, input logic nxt,
    input logic err);
    @(posedge clk);
    wordStrobe <= 1'b1;
    word <= w;
    wordIsNext <= nxt;
    wordError <= err;
    @(posedge clk);
    wordStrobe <= 1'b0;
    word <= ~w;
    wordIsNext <= ~nxt;
    wordError <= ~err;
  endtask
endmodule

// >>> sim/partner_ability_capture_tb.sv
`timescale 1ns/1ps
module partner_ability_capture_tb;
  import pac_pkg::*;
  logic clk, rst_n, regWr, regRd, negRestart, negComplete, pend;
  logic nextPageEnable, irq, wordStrobe, wordError, wordIsNext;
  pac_addr_type regAddr;
  pac_word_type regWrData, regRdData, word, w, prev;
  pac_word_type expQ[$];
  int nFail, nTests;
  integer seed;
  pac_partner_ability pac_partner_ability_inst (.*);
  pac_link_partner pac_link_partner_inst (.*);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task endSim;
    if (expQ.size() != 0) nFail++;
    $display("fails %0d tests %0d", nFail, nTests);
    if (nFail == 0 && nTests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task cmp(input pac_word_type g, input pac_word_type e);
    nTests++;
    if (g !== e) begin
      nFail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  always @(posedge clk) begin
    if (pend) cmp(regRdData, expQ.pop_front());
    pend <= regRd;
  end
  task wr(input pac_addr_type a, input pac_word_type d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task rd(input pac_addr_type a, input pac_word_type e);
    expQ.push_back(e);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
  endtask
  task irqIs(input logic e);
    repeat (3) @(posedge clk);
    nTests++;
    if (irq !== e) begin
      nFail++;
      $display("BAD t=%0t got=%h exp=%h", $time, irq, e);
    end
  endtask
  initial begin
    seed = 32'h06B5682C;
    {nFail, nTests, pend, prev} = '0;
    {rst_n, regWr, regRd, regAddr, regWrData, negRestart, negComplete} = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(5'h05, 16'h0000);
    rd(5'h12, 16'h0001);
    rd(5'h1F, 16'h0000);
    wr(5'h11, 16'h001F);
    for (int i = 0; i < 7; i++) begin
      w = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($random(seed));
      if (i == 6) wr(5'h11, 16'h0000);
      pac_link_partner_inst.send(w, 1'b0, 1'b0);
      rd(5'h05, w & 16'hEFFF);
      irqIs(i < 6);
      rd(5'h10, {11'h000, 1'b0, (w & 16'hEFFF) != prev, w[13],
        2'b01});
      prev = w & 16'hEFFF;
      irqIs(1'b0);
    end
    wr(5'h11, 16'h001F);
    pac_link_partner_inst.send(~prev, 1'b0, 1'b1);
    irqIs(1'b0);
    rd(5'h05, prev);
    wr(5'h05, 16'hFFFF);
    rd(5'h05, prev);
    negComplete <= 1'b1;
    w = 16'($random(seed)) | 16'h1000;
    pac_link_partner_inst.send(w, 1'b1, 1'b0);
    repeat (3) @(posedge clk);
    rd(5'h05, w);
    rd(5'h13, prev);
    irqIs(1'b1);
    rd(5'h14, 16'h0007);
    rd(5'h10, 16'h0012);
    @(posedge clk);
    negRestart <= 1'b1;
    @(posedge clk);
    negRestart <= 1'b0;
    repeat (2) @(posedge clk);
    rd(5'h05, prev);
    rd(5'h14, 16'h0004);
    wr(5'h12, 16'h0000);
    rd(5'h12, 16'h0000);
    // Next page arrives with next pages off, so view stays on base
    pac_link_partner_inst.send(~w, 1'b1, 1'b0);
    repeat (3) @(posedge clk);
    rd(5'h05, prev);
    rd(5'h14, 16'h0006);
    negComplete <= 1'b0;
    repeat (3) @(posedge clk);
    endSim;
  end
  initial begin
    repeat (2000) @(posedge clk);
    nFail++;
    endSim;
  end
endmodule
bind pac_partner_ability pac_properties pac_properties_inst (.*);
